// ==== core/eiu_consts.vh ====
// eiu_consts.vh: constants of the external interrupt unit
// assumes inclusion by bare name from the design file only
`ifndef EIU_CONSTS_VH
`define EIU_CONSTS_VH

// register map (word index, byte address is four times it)
`define EIU_STATUS_CTRL_IDX   2'h0
// bit positions in the status and control register
`define EIU_BIT_OSC_LOW       0
`define EIU_BIT_OSC_HIGH      1
`define EIU_BIT_PEND_CLEAR    2
`define EIU_BIT_PEND_FLAG     3
`define EIU_BIT_REQ_ENABLE    7
// reset values of the stored bits
`define EIU_RST_REQ_ENABLE    1'b1
`define EIU_RST_OSC_HIGH      1'b1
`define EIU_RST_OSC_LOW       1'b0

// vector pairs (high byte first, low byte at +1)
`define EIU_VEC_SOFT_TRAP     16'h1FFC
`define EIU_VEC_EXTERNAL      16'h1FFA

// interrupt frame: locations pushed on entry, popped on return
`define EIU_FRAME_LEN         3'h5
`define EIU_FRAME_LAST        3'h4

`endif

// ==== core/eiu_top.v ====
// eiu_top.v: external interrupt unit with its interrupt entry sequencer
// assumes one 50 MHz clock, pins synchronous to it, an Avalon-MM master
//
// Summary of operation
// - entry: push registers, set mask, load vector
// - return pops registers in reverse order
// - software trap always starts entry
// - mask set or enable clear blocks requests
// - instruction end samples latch, mask, enable
// - external vector fetch clears the request latch
// - latched request serviced once return clears mask
// - option selects edge or edge-and-level sensing
// - level mode: low pin keeps request present
// - edge mode: pin must rise, then fall
// - port option: rising port pin latches request
// - level mode: high port pin keeps request
// - edge mode: port pin must fall, rise
// - high port pin masks others; low pin masks ports
// - flag set by requests, unwritable, reset clears
// - flag clears on external vector fetch or clear write
// - clear bit write-only, reads zero
// - reset sets enable and high oscillator select
// - enable bit is read/write gate
// - select 00/10 internal, 01 crystal only
// - select 11 runs both, internal clocks
// - request under mask stays latched
// - entry pushes five, return pops five
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`include "eiu_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module eiu_top (
    input  wire        CLOCK_I,            // bus clock
    input  wire        RST_N_I,            // asynchronous reset, active low
    // avalon-mm slave
    input  wire [1:0]  AVS_ADDRESS_I,      // word address
    input  wire        AVS_READ_I,         // read request
    input  wire        AVS_WRITE_I,        // write request
    input  wire [3:0]  AVS_BYTEENABLE_I,   // byte lanes
    input  wire [31:0] AVS_WRITEDATA_I,    // write data
    output reg  [31:0] AVS_READDATA_O,     // read data
    output reg         AVS_WAITREQUEST_O,  // stall, high by default
    // request pins
    input  wire        IRQ_N_I,            // interrupt pin, active low
    input  wire [3:0]  PORT_IRQ_I,         // port interrupt pins, active high
    // one-time options
    input  wire        LEVEL_SENSE_I,      // 1 = edge-and-level, 0 = edge only
    input  wire        PORT_IRQ_OPTION_I,  // 1 = port pins are sources
    // cpu side
    input  wire        INSN_END_I,         // pulse: instruction completes
    input  wire        SOFT_TRAP_I,        // with INSN_END_I: trap instruction
    input  wire        RETURN_I,           // with INSN_END_I: return instruction
    input  wire        MASK_CLEAR_I,       // pulse: software clears mask
    input  wire        MASK_SET_I,         // pulse: software sets mask
    output reg         STACK_PUSH_O,       // pulse: push one location
    output reg         STACK_POP_O,        // pulse: pop one location
    output reg  [2:0]  STACK_SLOT_O,       // register slot being moved
    output reg         VECTOR_FETCH_O,     // pulse: vector byte fetch
    output reg  [15:0] VECTOR_ADDR_O,      // vector byte address
    output reg         MASK_O,             // global interrupt mask
    output reg         BUSY_O,             // sequence in progress
    output reg         IRQ_PENDING_O,      // request latch state
    output reg         LPO_ENABLE_O,       // internal oscillator on
    output reg         XTAL_ENABLE_O,      // crystal oscillator on
    output reg         CLK_SEL_XTAL_O      // cpu clocked from crystal
);

    // bus timing: a request seen with waitrequest high
    // drops waitrequest for one cycle; the access is
    // taken at the next edge, two edges per access
    // pin timing: two sync stages and the edge stage put
    // the latch three edges behind a pin change, and the
    // pending output one edge behind the latch

    // sequencer states
    localparam [2:0] ST_IDLE = 3'h0;   // waiting for instruction end
    localparam [2:0] ST_PUSH = 3'h1;   // stacking the frame
    localparam [2:0] ST_MASK = 3'h2;   // setting the mask
    localparam [2:0] ST_VECH = 3'h3;   // fetching vector high byte
    localparam [2:0] ST_VECL = 3'h4;   // fetching vector low byte
    localparam [2:0] ST_POP  = 3'h5;   // unstacking the frame

    // one byte register at word zero; the flag bit
    // is a view of the latch, not a second copy
    // pin synchronisers
    reg        irq_n_meta_r;          // first stage, interrupt pin
    reg        irq_n_sync_r;          // second stage, interrupt pin
    reg [3:0]  port_meta_r;           // first stage, port pins
    reg [3:0]  port_sync_r;           // second stage, port pins
    reg        line_prev_r;           // combined request line, last cycle
    // options caught once after reset release
    reg        opt_taken_r;           // options captured
    reg        level_mode_r;          // edge-and-level sensing
    reg        port_opt_r;            // port pins enabled
    // status and control bits
    reg        enable_r;              // external request enable
    reg        osc_high_r;            // high oscillator select
    reg        osc_low_r;             // low oscillator select
    reg        latch_r;               // request latch, seen as pending flag
    // sequencer
    reg [2:0]  state_r;               // current state
    reg [2:0]  slot_r;                // frame slot counter
    reg        trap_r;                // entry taken for the soft trap
    reg        saved_mask_r;          // mask value stacked with the frame

    wire       port_any;              // any enabled port pin high
    wire       req_line;              // combined request line
    wire       edge_hit;              // new request edge
    wire       level_hit;             // request held by level
    wire       bus_take;              // access completes this edge
    wire       reg_sel;               // status register addressed
    wire       wr_low;                // write reaching the low byte
    wire       clr_hit;               // software clear of the latch
    wire       vec_clear;             // latch cleared by vector fetch
    wire       take_ext;              // external entry accepted
    wire [7:0] status_byte;           // register read value

    // returns the status register image
    function [7:0] status_image;
        input en;
        input flag;
        input hi;
        input lo;
        begin
            status_image                       = 8'h00;
            status_image[`EIU_BIT_REQ_ENABLE]  = en;
            status_image[`EIU_BIT_PEND_FLAG]   = flag;
            status_image[`EIU_BIT_OSC_HIGH]    = hi;
            status_image[`EIU_BIT_OSC_LOW]     = lo;
        end
    endfunction

    // reset values equal the idle pin levels, so
    // no false edge follows reset release
    // the detector never reads the first stage
    // two-flop synchronisers on every pin
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_n_meta_r <= 1'b1;
            irq_n_sync_r <= 1'b1;
            port_meta_r  <= 4'h0;
            port_sync_r  <= 4'h0;
        end else begin
            irq_n_meta_r <= IRQ_N_I;
            irq_n_sync_r <= irq_n_meta_r;
            port_meta_r  <= PORT_IRQ_I;
            port_sync_r  <= port_meta_r;
        end
    end

    // catch the one-time options in the first cycle after release
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            opt_taken_r  <= 1'b0;
            level_mode_r <= 1'b0;
            port_opt_r   <= 1'b0;
        end else if (!opt_taken_r) begin
            opt_taken_r  <= 1'b1;
            level_mode_r <= LEVEL_SENSE_I;
            port_opt_r   <= PORT_IRQ_OPTION_I;
        end
    end

    // ports and pin share one line: while any is active the rest is hidden
    assign port_any  = |(port_sync_r & {4{port_opt_r}});
    assign req_line  = (~irq_n_sync_r) | port_any;
    // an edge needs the line to go inactive first
    assign edge_hit  = req_line & ~line_prev_r;
    // in level mode a held line keeps raising the request
    assign level_hit = level_mode_r & req_line;

    // combined line history
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            line_prev_r <= 1'b0;
        end else begin
            line_prev_r <= req_line;
        end
    end

    // bus decode: an access completes when waitrequest is low
    assign bus_take  = (AVS_READ_I | AVS_WRITE_I) & ~AVS_WAITREQUEST_O;
    assign reg_sel   = (AVS_ADDRESS_I == `EIU_STATUS_CTRL_IDX);
    assign wr_low    = bus_take & AVS_WRITE_I & reg_sel & AVS_BYTEENABLE_I[0];
    // writing 1 clears, writing 0 does nothing
    assign clr_hit   = wr_low & AVS_WRITEDATA_I[`EIU_BIT_PEND_CLEAR];
    assign vec_clear = (state_r == ST_VECH) & ~trap_r;
    assign take_ext  = latch_r & ~MASK_O & enable_r;
    // clear bit is never stored, so it reads zero
    assign status_byte = status_image(enable_r, latch_r, osc_high_r, osc_low_r);

    // one latch for every source: set by edge or level
    // hits, cleared by the clear bit or the external
    // vector fetch; a trap fetch leaves it alone
    // limitation: software polls pins to find the source
    // request latch: a new request wins over a clear in the same cycle
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            latch_r <= 1'b0;
        end else if (opt_taken_r && (edge_hit || level_hit)) begin
            latch_r <= 1'b1;
        end else if (clr_hit || vec_clear) begin
            latch_r <= 1'b0;
        end
    end

    // control bits; the flag position ignores writes
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            enable_r   <= `EIU_RST_REQ_ENABLE;
            osc_high_r <= `EIU_RST_OSC_HIGH;
            osc_low_r  <= `EIU_RST_OSC_LOW;
        end else if (wr_low) begin
            enable_r   <= AVS_WRITEDATA_I[`EIU_BIT_REQ_ENABLE];
            osc_high_r <= AVS_WRITEDATA_I[`EIU_BIT_OSC_HIGH];
            osc_low_r  <= AVS_WRITEDATA_I[`EIU_BIT_OSC_LOW];
        end
    end

    // read data is loaded in the wait cycle, so it
    // stands at the edge where the access is taken
    // waitrequest drops for one cycle per access; read data ready then
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            AVS_WAITREQUEST_O <= 1'b1;
            AVS_READDATA_O    <= 32'h00000000;
        end else if ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O) begin
            AVS_WAITREQUEST_O <= 1'b0;
            // unmapped words read as zero
            AVS_READDATA_O    <= reg_sel ? {24'h000000, status_byte} : 32'h00000000;
        end else begin
            AVS_WAITREQUEST_O <= 1'b1;
        end
    end

    // only code 01 switches the crystal in; code 11
    // lets it start while the internal oscillator
    // still clocks, so software can wait for it
    // oscillator controls decoded from the two select bits
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            LPO_ENABLE_O   <= 1'b1;
            XTAL_ENABLE_O  <= 1'b0;
            CLK_SEL_XTAL_O <= 1'b0;
        end else begin
            // 00 and 10: internal only; 01: crystal only
            LPO_ENABLE_O   <= ~(osc_low_r & ~osc_high_r);
            XTAL_ENABLE_O  <= osc_low_r;
            // 11 starts the crystal but keeps the internal clock
            CLK_SEL_XTAL_O <= osc_low_r & ~osc_high_r;
        end
    end

    // priority at instruction end: return, then trap,
    // then an accepted external request
    // entry: five pushes, mask, two vector fetches
    // return: five pops from the top slot; with the last
    // pop the mask comes back from the copy saved at entry
    // limitation: one saved copy, no nested entries
    // mask pulses are honoured only while idle
    // entry and return sequencer
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_r        <= ST_IDLE;
            slot_r         <= 3'h0;
            trap_r         <= 1'b0;
            saved_mask_r   <= 1'b1;
            MASK_O         <= 1'b1;
            STACK_PUSH_O   <= 1'b0;
            STACK_POP_O    <= 1'b0;
            STACK_SLOT_O   <= 3'h0;
            VECTOR_FETCH_O <= 1'b0;
            VECTOR_ADDR_O  <= 16'h0000;
            BUSY_O         <= 1'b0;
        end else begin
            STACK_PUSH_O   <= 1'b0;
            STACK_POP_O    <= 1'b0;
            VECTOR_FETCH_O <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    // software mask control between instructions
                    if (MASK_CLEAR_I) begin
                        MASK_O <= 1'b0;
                    end else if (MASK_SET_I) begin
                        MASK_O <= 1'b1;
                    end
                    if (INSN_END_I && RETURN_I) begin
                        state_r <= ST_POP;
                        slot_r  <= `EIU_FRAME_LAST;
                        BUSY_O  <= 1'b1;
                    end else if (INSN_END_I && SOFT_TRAP_I) begin
                        state_r      <= ST_PUSH;
                        trap_r       <= 1'b1;
                        slot_r       <= 3'h0;
                        saved_mask_r <= MASK_O;
                        BUSY_O       <= 1'b1;
                    end else if (INSN_END_I && take_ext) begin
                        state_r      <= ST_PUSH;
                        trap_r       <= 1'b0;
                        slot_r       <= 3'h0;
                        saved_mask_r <= MASK_O;
                        BUSY_O       <= 1'b1;
                    end
                end
                ST_PUSH: begin
                    // registers go onto the stack first
                    STACK_PUSH_O <= 1'b1;
                    STACK_SLOT_O <= slot_r;
                    if (slot_r == `EIU_FRAME_LAST) begin
                        state_r <= ST_MASK;
                    end else begin
                        slot_r  <= slot_r + 3'h1;
                    end
                end
                ST_MASK: begin
                    MASK_O  <= 1'b1;
                    state_r <= ST_VECH;
                end
                ST_VECH: begin
                    // external entry clears the latch here so new requests can be caught
                    VECTOR_FETCH_O <= 1'b1;
                    VECTOR_ADDR_O  <= trap_r ? `EIU_VEC_SOFT_TRAP : `EIU_VEC_EXTERNAL;
                    state_r        <= ST_VECL;
                end
                ST_VECL: begin
                    VECTOR_FETCH_O <= 1'b1;
                    VECTOR_ADDR_O  <= VECTOR_ADDR_O + 16'h0001;
                    state_r        <= ST_IDLE;
                    BUSY_O         <= 1'b0;
                end
                ST_POP: begin
                    // reverse order: last pushed slot comes back first
                    STACK_POP_O  <= 1'b1;
                    STACK_SLOT_O <= slot_r;
                    if (slot_r == 3'h0) begin
                        // condition codes restored: mask returns
                        MASK_O  <= saved_mask_r;
                        state_r <= ST_IDLE;
                        BUSY_O  <= 1'b0;
                    end else begin
                        slot_r  <= slot_r - 3'h1;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    BUSY_O  <= 1'b0;
                end
            endcase
        end
    end

    // registered copy keeps every output straight
    // from a flip-flop, at one cycle of latency
    // pending flag mirrored to a port
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            IRQ_PENDING_O <= 1'b0;
        end else begin
            IRQ_PENDING_O <= latch_r;
        end
    end

endmodule // eiu_top

`default_nettype wire

// ==== bench/eiu_properties.sv ====
// eiu_properties.sv: concurrent checks on the external interrupt unit ports
// assumes bound into eiu_top, one clock, reset asynchronous and active low
`timescale 1ns/1ns
`default_nettype none
module eiu_properties (
    input wire logic        CLOCK_I,
    input wire logic        RST_N_I,
    input wire logic        AVS_READ_I,
    input wire logic        AVS_WRITE_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic        AVS_WAITREQUEST_O,
    input wire logic        IRQ_N_I,
    input wire logic [3:0]  PORT_IRQ_I,
    input wire logic        INSN_END_I,
    input wire logic        SOFT_TRAP_I,
    input wire logic        RETURN_I,
    input wire logic        STACK_PUSH_O,
    input wire logic        STACK_POP_O,
    input wire logic [2:0]  STACK_SLOT_O,
    input wire logic        VECTOR_FETCH_O,
    input wire logic [15:0] VECTOR_ADDR_O,
    input wire logic        MASK_O,
    input wire logic        BUSY_O,
    input wire logic        IRQ_PENDING_O,
    input wire logic        LPO_ENABLE_O,
    input wire logic        XTAL_ENABLE_O,
    input wire logic        CLK_SEL_XTAL_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    // a bus access is answered within two cycles
    AST_BUS_ANSWER: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |-> ##[1:2] !AVS_WAITREQUEST_O) else $error("bus access not answered");
    // unused and write-only bits read back as zero
    AST_ZERO_BITS: assert property (!AVS_WAITREQUEST_O |-> AVS_READDATA_O[31:8] == 24'h0 && AVS_READDATA_O[6:4] == 3'h0 && !AVS_READDATA_O[2]) else $error("unused bits not zero");
    // entry pushes five slots, then masks, then fetches the vector pair
    AST_ENTRY_ORDER: assert property ($rose(BUSY_O) ##1 STACK_PUSH_O |-> STACK_PUSH_O[*5] ##1 (MASK_O && !STACK_PUSH_O) ##1 VECTOR_FETCH_O ##1 VECTOR_FETCH_O) else $error("entry sequence out of order");
    // vector pair: high byte address first, then the next one
    AST_VECTOR_PAIR: assert property (VECTOR_FETCH_O && !$past(VECTOR_FETCH_O) |-> (VECTOR_ADDR_O == 16'h1FFA || VECTOR_ADDR_O == 16'h1FFC) ##1 VECTOR_ADDR_O == $past(VECTOR_ADDR_O) + 16'h1) else $error("vector address wrong");
    // the trap instruction always starts entry
    AST_TRAP_ENTRY: assert property (INSN_END_I && SOFT_TRAP_I && !RETURN_I && !BUSY_O |=> BUSY_O ##1 STACK_PUSH_O) else $error("trap did not start entry");
    // an ordinary instruction end under mask starts nothing
    AST_MASK_BLOCKS: assert property (INSN_END_I && !SOFT_TRAP_I && !RETURN_I && !BUSY_O && MASK_O |=> !BUSY_O) else $error("entry taken under mask");
    // return pops from the top slot downward
    AST_RETURN_TOP: assert property (INSN_END_I && RETURN_I && !BUSY_O |=> BUSY_O ##1 (STACK_POP_O && STACK_SLOT_O == 3'h4)) else $error("return does not start at top slot");
    AST_POP_DOWN: assert property (STACK_POP_O && STACK_SLOT_O != 3'h0 |=> STACK_POP_O && STACK_SLOT_O == $past(STACK_SLOT_O) - 3'h1) else $error("pop order broken");
    // external vector fetch with quiet pins leaves the latch clear
    AST_FETCH_CLEARS: assert property (VECTOR_FETCH_O && VECTOR_ADDR_O == 16'h1FFA && IRQ_N_I && $past(IRQ_N_I) && $past(IRQ_N_I, 2) && $past(IRQ_N_I, 3) && PORT_IRQ_I == 4'h0 && $past(PORT_IRQ_I, 3) == 4'h0 |-> ##[1:3] !IRQ_PENDING_O) else $error("latch not cleared by fetch");
    // crystal selected only when it runs alone; some oscillator always runs
    AST_OSC_SEL: assert property (CLK_SEL_XTAL_O == (XTAL_ENABLE_O && !LPO_ENABLE_O) && (LPO_ENABLE_O || XTAL_ENABLE_O)) else $error("oscillator controls inconsistent");
    cover property ($rose(BUSY_O) ##1 STACK_PUSH_O);
    cover property (VECTOR_FETCH_O && VECTOR_ADDR_O == 16'h1FFC);
    cover property ($rose(STACK_POP_O));
    cover property ($rose(IRQ_PENDING_O));
endmodule // eiu_properties
bind eiu_top eiu_properties eiu_properties_i (.*);
`default_nettype wire

// ==== bench/eiu_pin_model.sv ====
// eiu_pin_model.sv: the request sources outside the unit
// assumes bench commands on the clock; interrupt line pulled up when idle
`timescale 1ns/1ns
`default_nettype none
module eiu_pin_model (
    input  wire logic       clk_i,         // bus clock
    input  wire logic [1:0] irq_src_low_i, // wired sources pulling the line low
    input  wire logic [3:0] port_src_i,    // port sources driving high
    output var  logic       irq_n_o,       // interrupt line
    output var  logic [3:0] port_o         // port lines
);
    // pull-up holds the line high before any source acts
    initial irq_n_o = 1'b1;
    initial port_o = 4'h0;
    // wired-OR: any source low keeps the line low
    always @(posedge clk_i) begin
        irq_n_o <= ~|irq_src_low_i;
        port_o  <= port_src_i;
    end
endmodule // eiu_pin_model
`default_nettype wire

// ==== bench/test_external_interrupt_unit.sv ====
// test_external_interrupt_unit.sv: self-checking bench for eiu_top
// assumes eiu_top, eiu_pin_model and the bound checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module test_external_interrupt_unit;
    logic        CLOCK_I = 1'b0;
    logic        RST_N_I = 1'b0;
    logic [1:0]  AVS_ADDRESS_I = 2'h0;
    logic        AVS_READ_I = 1'b0;
    logic        AVS_WRITE_I = 1'b0;
    logic [31:0] AVS_WRITEDATA_I = 32'h0;
    logic        LEVEL_SENSE_I = 1'b0;
    logic        PORT_IRQ_OPTION_I = 1'b0;
    logic        INSN_END_I = 1'b0;
    logic        SOFT_TRAP_I = 1'b0;
    logic        RETURN_I = 1'b0;
    logic        MASK_CLEAR_I = 1'b0;
    logic [1:0]  irq_src_low = 2'h0;   // commands to the pin model
    logic [3:0]  port_src = 4'h0;
    wire  [31:0] AVS_READDATA_O;
    wire         AVS_WAITREQUEST_O, IRQ_N_I, STACK_PUSH_O, STACK_POP_O, VECTOR_FETCH_O;
    wire  [3:0]  PORT_IRQ_I;
    wire  [2:0]  STACK_SLOT_O;
    wire  [15:0] VECTOR_ADDR_O;
    wire         MASK_O, BUSY_O, IRQ_PENDING_O, LPO_ENABLE_O, XTAL_ENABLE_O, CLK_SEL_XTAL_O;
    logic [31:0] q;                    // last read data
    logic [15:0] vec;                  // first vector address of a sequence
    int          pushes, err_total = 0, samples_checked = 0, cycles = 0;
    eiu_top eiu_top_i (.AVS_BYTEENABLE_I(4'hF), .MASK_SET_I(1'b0), .*);
    eiu_pin_model eiu_pin_model_i (.clk_i(CLOCK_I), .irq_src_low_i(irq_src_low),
        .port_src_i(port_src), .irq_n_o(IRQ_N_I), .port_o(PORT_IRQ_I));
    initial forever #10 CLOCK_I = ~CLOCK_I;
    // hang guard
    always @(posedge CLOCK_I) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            end_of_test();
        end
    end
    task end_of_test;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one Avalon access, held until waitrequest is sampled low
    task bus(input logic wr, input logic [1:0] a, input logic [7:0] d);
        @(posedge CLOCK_I);
        AVS_ADDRESS_I <= a;
        AVS_WRITE_I <= wr;
        AVS_READ_I <= !wr;
        AVS_WRITEDATA_I <= {24'h0, d};
        do @(posedge CLOCK_I); while (AVS_WAITREQUEST_O !== 1'b0);
        q = AVS_READDATA_O;
        AVS_READ_I <= 1'b0;
        AVS_WRITE_I <= 1'b0;
    endtask
    // instruction end, optionally a trap or a return
    task insn(input logic t, input logic r);
        @(posedge CLOCK_I);
        INSN_END_I <= 1'b1;
        SOFT_TRAP_I <= t;
        RETURN_I <= r;
        @(posedge CLOCK_I);
        INSN_END_I <= 1'b0;
        SOFT_TRAP_I <= 1'b0;
        RETURN_I <= 1'b0;
        #1;
    endtask
    task mclr;
        @(posedge CLOCK_I);
        MASK_CLEAR_I <= 1'b1;
        @(posedge CLOCK_I);
        MASK_CLEAR_I <= 1'b0;
    endtask
    task idle(input int n);
        repeat (n) @(posedge CLOCK_I);
    endtask
    // watch a whole entry or return sequence
    task seq;
        pushes = 0;
        vec = 16'h0;
        repeat (14) begin
            @(posedge CLOCK_I);
            if (STACK_PUSH_O === 1'b1) pushes++;
            if (VECTOR_FETCH_O === 1'b1 && vec == 16'h0) vec = VECTOR_ADDR_O;
        end
    endtask
    task rst(input logic lvl, input logic opt);
        @(posedge CLOCK_I);
        RST_N_I <= 1'b0;
        LEVEL_SENSE_I <= lvl;
        PORT_IRQ_OPTION_I <= opt;
        idle(2);
        RST_N_I <= 1'b1;
    endtask
    // register image: enable, pending flag, oscillator selects
    function automatic logic [31:0] exp_reg(input logic en, input logic fl, input logic [1:0] v);
        exp_reg = {24'h0, en, 3'h0, fl, 1'b0, v};
    endfunction
    // {internal on, crystal on, crystal selected}
    function automatic logic [2:0] exp_osc(input logic [1:0] v);
        exp_osc = (v == 2'h1) ? 3'b011 : {1'b1, v == 2'h3, 1'b0};
    endfunction
    initial begin
        q = $urandom(99);
        for (int p = 0; p < 2; p++) begin
            // pass 0: edge only with port pins; pass 1: edge-and-level without them
            rst(p == 1, p == 0);
            bus(0, 2'h0, 8'h0);
            chk("reset reg", q, exp_reg(1'b1, 1'b0, 2'h2));
            bus(0, 2'(1 + $urandom % 3), 8'h0);
            chk("unmapped", q, 32'h0);
            for (int v = 0; v < 4; v++) begin
                bus(1, 2'h0, {1'b1, 3'($urandom), 1'b1, 1'($urandom), 2'(v)});
                bus(0, 2'h0, 8'h0);
                chk("reg", q, exp_reg(1'b1, 1'b0, 2'(v)));
                chk("osc", {LPO_ENABLE_O, XTAL_ENABLE_O, CLK_SEL_XTAL_O}, exp_osc(2'(v)));
            end
            bus(1, 2'h0, 8'h82);
            irq_src_low <= {1'($urandom), 1'b1};
            idle(6);
            bus(0, 2'h0, 8'h0);
            chk("flag", q[3], 1'b1);
            insn(0, 0);
            chk("busy masked", BUSY_O, 1'b0);
            mclr;
            insn(0, 0);
            chk("busy", BUSY_O, 1'b1);
            seq;
            chk("pushes", pushes, 5);
            chk("vector", vec, 16'h1FFA);
            idle(2);
            chk("latch held", IRQ_PENDING_O, p == 1);
            insn(0, 1);
            seq;
            chk("mask back", MASK_O, 1'b0);
            irq_src_low <= 2'h0;
            idle(6);
            bus(1, 2'h0, 8'h86);
            bus(0, 2'h0, 8'h0);
            chk("flag cleared", q[3], 1'b0);
            bus(1, 2'h0, 8'h02);
            irq_src_low <= 2'h1;
            idle(6);
            irq_src_low <= 2'h0;
            idle(6);
            insn(0, 0);
            chk("busy disabled", BUSY_O, 1'b0);
            bus(1, 2'h0, 8'h82);
            insn(0, 0);
            chk("busy enabled", BUSY_O, 1'b1);
            seq;
            idle(2);
            chk("latch cleared", IRQ_PENDING_O, 1'b0);
            insn(0, 1);
            seq;
            port_src <= 4'(4'h1 << ($urandom % 4));
            idle(6);
            chk("port", IRQ_PENDING_O, p == 0);
            bus(1, 2'h0, 8'h86);
            irq_src_low <= 2'h1;
            idle(6);
            chk("port hides pin", IRQ_PENDING_O, p == 1);
            irq_src_low <= 2'h0;
            port_src <= 4'h0;
            idle(6);
            bus(1, 2'h0, 8'h06);
            insn(1, 0);
            chk("trap", BUSY_O, 1'b1);
            seq;
            chk("trap vector", vec, 16'h1FFC);
            insn(0, 1);
            seq;
        end
        end_of_test;
    end
endmodule // test_external_interrupt_unit
`default_nettype wire
